// [logic/oft_ctrl.sv]
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// Purpose: Output fault line, protection, relay and trigger-out control of a power module
// Assumes: Register port on the module clock; status pins are asynchronous
// Notes:   Relay option is a strap sampled after reset release
// How it works
// R01: Fault line driven only while enabled; enable clears on reset.
// R02: Fault event mask is writable, may be zero, resets to summary.
// R03: Fault source accepts only the linked option and reads it back.
// R04: Protection clear drops trips and restores the earlier output state.
// R05: Delay holds 0..32767 ms, resets to 100 ms; min and max readable.
// R06: Regulation states latch only after the delay following a reprogramming.
// R07: Overcurrent protection waits for the delay; overvoltage acts at once.
// R08: Relay bit closes contacts, independent of output enable; resets open.
// R09: Without relay option, relay writes are dropped and set an error.
// R10: Polarity bit passes output same or inverted; resets to same.
// R11: Relay change with output on forces output voltage to zero.
// R12: Trigger-out ORs this module's gated pulse with all module lines.
// R13: Combined trigger-out is offered back as a trigger input; the code only drives it out, and no trigger source reads it.
// R14: Trigger event mask acts only with linked source; resets to none.
// R15: Trigger source is bus, backplane, linked events or hold; resets to bus.
// R16: Hold source pulses only on the immediate trigger command.
// R17: A rising event at the chosen source emits one trigger-out pulse.
// R18: Pulse lasts a fixed cycle count, once per rising edge.
module oft_ctrl
    import oft_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              relay_fitted,
    input  wire logic              output_on,
    input  wire logic              reprogram,
    input  wire logic              const_voltage_state,
    input  wire logic              const_current_state,
    input  wire logic              unregulated_state,
    input  wire logic              ov_detect,
    input  wire logic              oc_detect,
    input  wire logic              ot_detect,
    input  wire logic              inhibit_detect,
    input  wire logic              summary_event,
    input  wire logic              backplane_trigger_in,
    input  wire logic              module_trigger_bus,
    output logic                   fault_indicator_line,
    output logic                   module_trigger_line,
    output logic                   trig_out_combined,
    output logic                   output_allowed,
    output logic                   force_zero_volts,
    output logic                   relay_closed,
    output logic                   relay_inverted,
    output logic [2:0]             oper_condition,
    output logic                   cmd_error
);
    localparam int unsigned SYNC_W = 10;

    // Two-stage synchronisers for the status and trigger pin inputs
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [SYNC_W-1:0] pins;
    assign pins = {module_trigger_bus, backplane_trigger_in, summary_event, inhibit_detect,
                   ot_detect, oc_detect, ov_detect, unregulated_state,
                   const_current_state, const_voltage_state};

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= pins;
            sync_b <= sync_a;
        end
    end

    logic s_cv, s_cc, s_unregulated_state, s_ov, s_oc, s_ot, s_ri, s_sum, s_ext, s_bus;
    assign {s_bus, s_ext, s_sum, s_ri, s_ot, s_oc, s_ov, s_unregulated_state, s_cc, s_cv} = sync_b;

    // Configuration and protection state
    logic             fault_en, next_fault_en;
    logic             relay, next_relay;
    logic             pol_inv, next_pol_inv;
    logic             trig_en, next_trig_en;
    oft_src_e         src, next_src;
    logic [EV_W-1:0]  fault_sel, next_fault_sel;
    logic [EV_W-1:0]  trig_sel, next_trig_sel;
    logic [15:0]      delay_ms, next_delay_ms;
    logic [3:0]       trips, next_trips;
    logic             saved_on, next_saved_on;
    logic             err, next_err;
    logic [2:0]       cond, next_cond;
    logic             strap_done, relay_opt, next_relay_opt;
    logic             relay_change;

    oft_delay_if dly_if ();
    oft_delay_timer u_delay (
        .clock  (clock),
        .arst_n (arst_n),
        .dly    (dly_if.timer)
    );

    // Relay switching window counter
    logic [15:0] relay_cnt, next_relay_cnt;

    logic cmd_wr;
    assign cmd_wr = wr && (addr == REG_CMD);

    logic any_trip;
    assign any_trip = |trips;

    always_comb
    begin
        next_fault_en  = fault_en;
        next_relay     = relay;
        next_pol_inv   = pol_inv;
        next_trig_en   = trig_en;
        next_src       = src;
        next_fault_sel = fault_sel;
        next_trig_sel  = trig_sel;
        next_delay_ms  = delay_ms;
        next_trips     = trips;
        next_saved_on  = saved_on;
        next_err       = err;
        next_cond      = cond;
        next_relay_opt = relay_opt;
        relay_change   = 1'b0;
        if (!strap_done)
            next_relay_opt = relay_fitted;
        if (wr)
        begin
            if (addr == REG_CTRL)
            begin
                next_fault_en = wdata[CTRL_FAULT_EN];                    // R01
                next_trig_en  = wdata[CTRL_TRIG_EN];                     // R12
                next_src      = oft_src_e'(wdata[CTRL_SRC_LSB +: 2]);    // R15
                if (!wdata[CTRL_FSRC])
                    next_err = 1'b1;                                     // R03
                if ((wdata[CTRL_RELAY] != relay) || (wdata[CTRL_POL_INV] != pol_inv))
                begin
                    if (relay_opt)
                    begin
                        next_relay   = wdata[CTRL_RELAY];                // R08
                        next_pol_inv = wdata[CTRL_POL_INV];              // R10
                        relay_change = 1'b1;
                    end
                    else
                        next_err = 1'b1;                                 // R09
                end
            end
            else if (addr == REG_FAULT_SEL)
                next_fault_sel = wdata[EV_W-1:0];                        // R02
            else if (addr == REG_TRIG_SEL)
                next_trig_sel = wdata[EV_W-1:0];                         // R14
            else if (addr == REG_DELAY)
            begin
                if (wdata > DELAY_MS_MAX)
                    next_err = 1'b1;                                     // R05
                else
                    next_delay_ms = wdata;                               // R05
            end
        end
        if (cmd_wr && wdata[CMD_ERR_CLR])
            next_err = 1'b0;
        // Set wins over clear so no trip is lost
        if (cmd_wr && wdata[CMD_PROT_CLR])
            next_trips = 4'h0;                                           // R04
        if (!any_trip)
            next_saved_on = output_on;                                   // R04
        if (s_ov)
            next_trips[0] = 1'b1;                                        // R07
        if (s_oc && cond[EV_CC] && !dly_if.busy)
            next_trips[1] = 1'b1;                                        // R07
        if (s_ot)
            next_trips[2] = 1'b1;
        if (s_ri)
            next_trips[3] = 1'b1;
        if (!dly_if.busy && !reprogram)
            next_cond = {s_unregulated_state, s_cc, s_cv};                           // R06
    end

    assign dly_if.start    = reprogram;                                  // R06
    assign dly_if.delay_ms = delay_ms;

    always_comb
    begin
        next_relay_cnt = relay_cnt;
        if (relay_change && output_on)
            next_relay_cnt = 16'(RELAY_CYCLES);                          // R11
        else if (relay_cnt != 16'h0)
            next_relay_cnt = relay_cnt - 16'h1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_en   <= 1'b0;
            relay      <= 1'b0;
            pol_inv    <= 1'b0;
            trig_en    <= 1'b0;
            src        <= OFT_SRC_BUS;
            fault_sel  <= FAULT_SEL_RST;
            trig_sel   <= TRIG_SEL_RST;
            delay_ms   <= DELAY_MS_RST;
            trips      <= 4'h0;
            saved_on   <= 1'b0;
            err        <= 1'b0;
            cond       <= 3'h0;
            relay_opt  <= 1'b0;
            strap_done <= 1'b0;
            relay_cnt  <= 16'h0;
        end
        else
        begin
            fault_en   <= next_fault_en;
            relay      <= next_relay;
            pol_inv    <= next_pol_inv;
            trig_en    <= next_trig_en;
            src        <= next_src;
            fault_sel  <= next_fault_sel;
            trig_sel   <= next_trig_sel;
            delay_ms   <= next_delay_ms;
            trips      <= next_trips;
            saved_on   <= next_saved_on;
            err        <= next_err;
            cond       <= next_cond;
            relay_opt  <= next_relay_opt;
            strap_done <= 1'b1;
            relay_cnt  <= next_relay_cnt;
        end
    end

    // Event vector shared by both selectors
    logic [EV_W-1:0] events;
    assign events = {s_sum, s_ri, s_ot, trips[1], trips[0], cond};

    // Trigger-out source and pulse shaping
    logic src_level;
    logic src_prev, next_src_prev;
    logic [3:0] pulse_cnt, next_pulse_cnt;
    logic imm_trig;
    assign imm_trig = cmd_wr && wdata[CMD_IMM_TRIG];

    always_comb
    begin
        src_level = 1'b0;
        case (src)
            OFT_SRC_BUS:  src_level = cmd_wr && wdata[CMD_BUS_TRIG];     // R15
            OFT_SRC_EXT:  src_level = s_ext;                             // R15
            OFT_SRC_LINK: src_level = |(events & trig_sel);              // R14
            OFT_SRC_HOLD: src_level = 1'b0;                              // R16
            default:      src_level = 1'b0;
        endcase
    end

    always_comb
    begin
        next_src_prev  = src_level;
        next_pulse_cnt = pulse_cnt;
        if ((src_level && !src_prev) || imm_trig)
            next_pulse_cnt = 4'(PULSE_CYCLES);                           // R17
        else if (pulse_cnt != 4'h0)
            next_pulse_cnt = pulse_cnt - 4'h1;                           // R18
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_prev  <= 1'b0;
            pulse_cnt <= 4'h0;
        end
        else
        begin
            src_prev  <= next_src_prev;
            pulse_cnt <= next_pulse_cnt;
        end
    end

    assign module_trigger_line  = trig_en && (pulse_cnt != 4'h0);        // R12
    assign trig_out_combined    = module_trigger_line || s_bus;          // R13
    assign fault_indicator_line = fault_en && |(events & fault_sel);     // R01
    assign output_allowed       = any_trip ? 1'b0 : saved_on;            // R04
    assign force_zero_volts     = (relay_cnt != 16'h0);                  // R11
    assign relay_closed         = relay;
    assign relay_inverted       = pol_inv;
    assign oper_condition       = cond;
    assign cmd_error            = err;

    // Read port: data stand one cycle after the strobe
    logic [DATA_W-1:0] next_rdata;
    always_comb
    begin
        next_rdata = '0;
        if (!rd)
            next_rdata = '0;
        else if (addr == REG_CTRL)
            next_rdata = 16'({1'b1, src, trig_en, pol_inv, relay, fault_en});
        else if (addr == REG_FAULT_SEL)
            next_rdata = 16'(fault_sel);
        else if (addr == REG_DELAY)
            next_rdata = delay_ms;
        else if (addr == REG_TRIG_SEL)
            next_rdata = 16'(trig_sel);
        else if (addr == REG_STATUS)
            next_rdata = 16'({relay_opt, force_zero_volts, err, trips, cond});
        else if (addr == REG_DELAY_MIN)
            next_rdata = DELAY_MS_MIN;
        else if (addr == REG_DELAY_MAX)
            next_rdata = DELAY_MS_MAX;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= '0;
        else
            rdata <= next_rdata;
    end
endmodule

// [logic/oft_pkg.sv]
// Purpose: Shared constants and types for the output fault and trigger control block
// Assumes: 10 MHz module clock, plain register port with one-cycle read latency
// Notes:   Offsets are word indices on the register port
package oft_pkg;
    localparam int unsigned  CLK_HZ        = 10_000_000;
    localparam int unsigned  ADDR_W        = 4;
    localparam int unsigned  DATA_W        = 16;
    // Register offsets
    localparam logic [3:0]   REG_CTRL      = 4'h0;
    localparam logic [3:0]   REG_FAULT_SEL = 4'h1;
    localparam logic [3:0]   REG_DELAY     = 4'h2;
    localparam logic [3:0]   REG_TRIG_SEL  = 4'h3;
    localparam logic [3:0]   REG_CMD       = 4'h4;
    localparam logic [3:0]   REG_STATUS    = 4'h5;
    localparam logic [3:0]   REG_DELAY_MIN = 4'h6;
    localparam logic [3:0]   REG_DELAY_MAX = 4'h7;
    // Control register fields
    localparam int unsigned  CTRL_FAULT_EN = 0;
    localparam int unsigned  CTRL_RELAY    = 1;
    localparam int unsigned  CTRL_POL_INV  = 2;
    localparam int unsigned  CTRL_TRIG_EN  = 3;
    localparam int unsigned  CTRL_SRC_LSB  = 4;
    localparam int unsigned  CTRL_FSRC     = 6;
    // Command register fields (write-one pulses)
    localparam int unsigned  CMD_PROT_CLR  = 0;
    localparam int unsigned  CMD_IMM_TRIG  = 1;
    localparam int unsigned  CMD_BUS_TRIG  = 2;
    localparam int unsigned  CMD_ERR_CLR   = 3;
    // Event bit positions shared by both event selectors
    localparam int unsigned  EV_CV         = 0;
    localparam int unsigned  EV_CC         = 1;
    localparam int unsigned  EV_UNREGULATED_STATE      = 2;
    localparam int unsigned  EV_OV         = 3;
    localparam int unsigned  EV_OC         = 4;
    localparam int unsigned  EV_OT         = 5;
    localparam int unsigned  EV_RI         = 6;
    localparam int unsigned  EV_SUMMARY    = 7;
    localparam int unsigned  EV_W          = 8;
    // Reset values
    localparam logic [7:0]   FAULT_SEL_RST = 8'h80;
    localparam logic [7:0]   TRIG_SEL_RST  = 8'h00;
    // Delay in milliseconds, 0 .. 32767
    localparam logic [15:0]  DELAY_MS_RST  = 16'h0064;
    localparam logic [15:0]  DELAY_MS_MIN  = 16'h0000;
    localparam logic [15:0]  DELAY_MS_MAX  = 16'h7fff;
    localparam int unsigned  MS_CYCLES     = CLK_HZ / 1000;
    // Relay switching and trigger pulse
    localparam int unsigned  RELAY_MS      = 5;
    localparam int unsigned  RELAY_CYCLES  = RELAY_MS * MS_CYCLES;
    localparam int unsigned  PULSE_CYCLES  = 8;

    typedef enum logic [1:0] {
        OFT_SRC_BUS,
        OFT_SRC_EXT,
        OFT_SRC_LINK,
        OFT_SRC_HOLD
    } oft_src_e;
endpackage

// [logic/oft_delay_if.sv]
`timescale 1ns/100ps
// Purpose: Carries settling-delay control between the top and its timer
// Assumes: One clock domain
// Notes:   Start restarts the timer; busy stays high while waiting
interface oft_delay_if;
    logic        start;
    logic [15:0] delay_ms;
    logic        busy;
    modport ctrl  (output start, output delay_ms, input busy);
    modport timer (input start, input delay_ms, output busy);
endinterface

// [logic/oft_delay_timer.sv]
`timescale 1ns/100ps
// Purpose: Millisecond settling timer used after output reprogramming
// Assumes: Module clock at the package rate
// Notes:   A restart while busy begins the full delay again
module oft_delay_timer
    import oft_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  arst_n,
    oft_delay_if.timer dly
);
    logic [23:0] tick;
    logic [23:0] next_tick;
    logic [15:0] ms_left;
    logic [15:0] next_ms_left;
    logic        busy;
    logic        next_busy;

    always_comb
    begin
        next_tick    = tick;
        next_ms_left = ms_left;
        next_busy    = busy;
        if (dly.start)
        begin
            next_tick    = 24'h0;
            next_ms_left = dly.delay_ms;
            next_busy    = (dly.delay_ms != 16'h0);
        end
        else if (busy)
        begin
            if (tick == 24'(MS_CYCLES - 1))
            begin
                next_tick    = 24'h0;
                next_ms_left = ms_left - 16'h1;
                if (ms_left == 16'h1)
                    next_busy = 1'b0;
            end
            else
                next_tick = tick + 24'h1;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick    <= 24'h0;
            ms_left <= 16'h0;
            busy    <= 1'b0;
        end
        else
        begin
            tick    <= next_tick;
            ms_left <= next_ms_left;
            busy    <= next_busy;
        end
    end

    assign dly.busy = busy;
endmodule

// [bench/oft_ctrl_properties.sv]
// Purpose: Port checks for the output fault and trigger control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Shadows of written fields judge outputs against their cause
`timescale 1ns/100ps
module oft_ctrl_properties
    import oft_pkg::*;
(
    input wire logic              clock,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              output_on,
    input wire logic              reprogram,
    input wire logic              ov_detect,
    input wire logic              fault_indicator_line,
    input wire logic              module_trigger_line,
    input wire logic              trig_out_combined,
    input wire logic              output_allowed,
    input wire logic              force_zero_volts,
    input wire logic              relay_closed,
    input wire logic [2:0]        oper_condition,
    input wire logic              cmd_error
);
    logic [15:0] dly_q;
    logic        fen_q;
    logic        ten_q;
    logic        ctrl_wr;

    assign ctrl_wr = wr && addr == REG_CTRL;

    // Refused delay values leave the shadow alone
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dly_q <= DELAY_MS_RST;
            fen_q <= 1'b0;
            ten_q <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                fen_q <= wdata[CTRL_FAULT_EN];
                ten_q <= wdata[CTRL_TRIG_EN];
            end
            if (wr && addr == REG_DELAY && wdata <= DELAY_MS_MAX)
                dly_q <= wdata;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence pulse_body;
        module_trigger_line [*8] ##1 !module_trigger_line;
    endsequence

    sequence ov_held;
        $rose(ov_detect) ##1 ov_detect [*3];
    endsequence

    fault_gate_a: assert property (!fen_q |-> !fault_indicator_line)
        else $error("fault line driven while disabled");
    fault_src_a: assert property ($past(rd) && $past(addr) == REG_CTRL |-> rdata[CTRL_FSRC])
        else $error("fault source does not read as linked");
    delay_max_a: assert property ($past(rd) && $past(addr) == REG_DELAY_MAX |-> rdata == DELAY_MS_MAX)
        else $error("delay maximum reads wrong");
    delay_err_a: assert property (wr && addr == REG_DELAY && wdata > DELAY_MS_MAX |=> cmd_error)
        else $error("oversize delay not flagged");
    cond_quiet_a: assert property (reprogram && dly_q != 16'h0000 |-> ##2 $stable(oper_condition) [*8])
        else $error("condition latched inside settling delay");
    ov_fast_a: assert property (ov_held |-> ##[0:2] !output_allowed)
        else $error("overvoltage did not stop output");
    relay_cause_a: assert property ($rose(relay_closed) |-> $past(ctrl_wr && wdata[CTRL_RELAY]))
        else $error("relay closed without command");
    zero_cause_a: assert property ($rose(force_zero_volts) |-> $past(output_on))
        else $error("zero forced with output off");
    trig_gate_a: assert property ($rose(module_trigger_line) |-> ten_q)
        else $error("pulse while trigger out disabled");
    trig_or_a: assert property (module_trigger_line |-> trig_out_combined)
        else $error("combined trigger misses own pulse");
    pulse_len_a: assert property ($rose(module_trigger_line) |-> pulse_body)
        else $error("trigger pulse length wrong");
endmodule

// [bench/oft_backplane_model.sv]
// Purpose: Mainframe backplane model joining the trigger lines of all modules
// Assumes: Peer modules are represented by one level from the bench
// Notes:   Registered like a slow wired-OR, so the bus lags the lines by a cycle
`timescale 1ns/100ps
module oft_backplane_model
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic module_trigger_line,
    input  wire logic peer_trigger,
    output logic      module_trigger_bus
);
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            module_trigger_bus <= 1'b0;
        else
            module_trigger_bus <= module_trigger_line | peer_trigger;
    end
endmodule

// [bench/output_fault_trigger_control_tb.sv]
// Purpose: Self-checking bench for the output fault and trigger control block
// Assumes: Register port with one-cycle read latency, 10 MHz clock
// Notes:   Settling and relay times run at full length
`timescale 1ns/100ps
module output_fault_trigger_control_tb
    import oft_pkg::*;
;
    logic        clock = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic        relay_fitted = 1'b0, output_on = 1'b0, reprogram = 1'b0, peer_trigger = 1'b0;
    logic        cv = 1'b0, cc = 1'b0, summary_event = 1'b0, backplane_trigger_in = 1'b0;
    logic [3:0]  trips = 4'h0;
    logic        module_trigger_bus, fault_indicator_line, module_trigger_line, trig_out_combined;
    logic        output_allowed, force_zero_volts, relay_closed, relay_inverted, cmd_error;
    logic [2:0]  oper_condition;
    int          bad_count = 0, compares = 0;

    oft_ctrl oft_ctrl_i (.*, .const_voltage_state(cv), .const_current_state(cc),
        .unregulated_state(1'b0), .ov_detect(trips[0]), .oc_detect(trips[1]),
        .ot_detect(trips[2]), .inhibit_detect(trips[3]));

    oft_backplane_model oft_backplane_model_i (.*);

    initial
    begin
        forever #50 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic settle;
        repeat (5) @(posedge clock);
        #1;
    endtask

    // High cycles of own trigger line, from the strobe's edge on
    task automatic count_pulse(input int exp);
        int n;
        n = 0;
        repeat (40)
        begin
            #1;
            if (module_trigger_line === 1'b1)
                n++;
            @(posedge clock);
        end
        check(16'(n), 16'(exp));
    endtask

    // Waits for 0: cc, 1: output stop, 2: zero release
    task automatic timed(input int which, input int lo, input int hi);
        int n;
        n = 0;
        while (n <= hi && !((which == 0 && oper_condition === 3'b010)
            || (which == 1 && output_allowed === 1'b0)
            || (which == 2 && force_zero_volts === 1'b0)))
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check(16'(n >= lo && n <= hi), 16'h0001);
    endtask

    task automatic do_reset(input logic fitted);
        @(posedge clock);
        arst_n <= 1'b0;
        relay_fitted <= fitted;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
    endtask

    task automatic pulse_reprogram;
        @(posedge clock);
        reprogram <= 1'b1;
        @(posedge clock);
        reprogram <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        do_reset(1'b0);
        rchk(REG_CTRL, 16'h0040);
        rchk(REG_FAULT_SEL, 16'h0080);
        rchk(REG_DELAY, DELAY_MS_RST);
        rchk(REG_DELAY_MIN, DELAY_MS_MIN);
        rchk(REG_DELAY_MAX, DELAY_MS_MAX);
        rchk(REG_TRIG_SEL, 16'h0000);
        rchk(4'h8, 16'h0000);
        summary_event <= 1'b1;
        settle();
        check(fault_indicator_line, 1'b0);
        wr_reg(REG_CTRL, 16'h0041);
        settle();
        check(fault_indicator_line, 1'b1);
        wr_reg(REG_FAULT_SEL, 16'h0000);
        settle();
        check(fault_indicator_line, 1'b0);
        wr_reg(REG_CTRL, 16'h0000);
        settle();
        check(cmd_error, 1'b1);
        rchk(REG_CTRL, 16'h0040);
        wr_reg(REG_CMD, 16'h0008);
        wr_reg(REG_CTRL, 16'h0046);
        settle();
        check({relay_closed, relay_inverted, cmd_error}, 3'b001);
        wr_reg(REG_DELAY, 16'h8000);
        rchk(REG_DELAY, 16'h0064);
        wr_reg(REG_DELAY, 16'h0001);
        rchk(REG_DELAY, 16'h0001);
        cv <= 1'b1;
        settle();
        check(oper_condition, 3'b001);
        pulse_reprogram();
        cv <= 1'b0;
        cc <= 1'b1;
        repeat (100) @(posedge clock);
        #1;
        check(oper_condition, 3'b001);
        timed(0, 9700, 10100);
        output_on <= 1'b1;
        settle();
        check(output_allowed, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            trips <= 4'(1 << i);
            settle();
            check(output_allowed, 1'b0);
            rchk(REG_STATUS, 16'((8 << i) | 16'h0082));
            trips <= 4'h0;
            settle();
            check(output_allowed, 1'b0);
            wr_reg(REG_CMD, 16'h0001);
            settle();
            check(output_allowed, 1'b1);
        end
        pulse_reprogram();
        trips <= 4'h2;
        repeat (100) @(posedge clock);
        #1;
        check(output_allowed, 1'b1);
        timed(1, 9700, 10100);
        trips <= 4'h0;
        wr_reg(REG_CMD, 16'h0009);
        do_reset(1'b1);
        wr_reg(REG_CTRL, 16'h0042);
        repeat (2) @(posedge clock);
        #1;
        check({relay_closed, force_zero_volts, cmd_error}, 3'b110);
        timed(2, 49800, 50100);
        output_on <= 1'b0;
        wr_reg(REG_CTRL, 16'h0046);
        settle();
        check({relay_closed, relay_inverted, force_zero_volts}, 3'b110);
        wr_reg(REG_CTRL, 16'h0048);
        wr_reg(REG_CMD, 16'h0004);
        count_pulse(8);
        wr_reg(REG_CTRL, 16'h0040);
        wr_reg(REG_CMD, 16'h0004);
        count_pulse(0);
        wr_reg(REG_CTRL, 16'h0058);
        backplane_trigger_in <= 1'b1;
        count_pulse(8);
        count_pulse(0);
        backplane_trigger_in <= 1'b0;
        summary_event <= 1'b0;
        wr_reg(REG_CTRL, 16'h0068);
        wr_reg(REG_CMD, 16'h0004);
        count_pulse(0);
        summary_event <= 1'b1;
        count_pulse(0);
        summary_event <= 1'b0;
        wr_reg(REG_TRIG_SEL, 16'h0080);
        settle();
        summary_event <= 1'b1;
        count_pulse(8);
        wr_reg(REG_CTRL, 16'h0078);
        wr_reg(REG_CMD, 16'h0004);
        count_pulse(0);
        wr_reg(REG_CMD, 16'h0002);
        count_pulse(8);
        peer_trigger <= 1'b1;
        settle();
        check({module_trigger_line, trig_out_combined}, 2'b01);
        report_and_stop();
    end
endmodule

bind oft_ctrl oft_ctrl_properties oft_ctrl_properties_i (.*);
